// ==== verilog/sctf_codec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sctf_defines.svh"
// Summary of operation
// - One, two or four 8/10-bit characters per word.
// - With encoder on, extra bits steer encoder.
// - Bypass order: mode, value, data bit 7..0.
// - Transmit running disparity resets negative.
// - Transmit running disparity always visible.
// - Per-byte mode/value force or invert disparity.
// - Four-deep FIFO, overflow/underflow flags, bypass option.
// - Least-significant byte goes first, both directions.
// - Full 256 data, 12 control code set.
// - Nine bits in, ten-bit code out.
// - Control flag picks control or data coding.
// - Invalid control byte raises transmit error.
// - Decoder bypass maps bits to flag, disparity, data.
// - Valid code with wrong disparity flags error.
// - Unknown code flags out-of-band, independent flag.
// - Disparity tracked for legal and illegal codes.
// - Out-of-band code passes raw bits through.
// - Twelve valid control characters raise flag.
// - Six comma modes: any or defined, polarity.
// - Every receive lane has own indicators.
module sctf_codec
(
  // Clock, reset and clock enable.
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Static configuration.
  input  wire logic        encoder_bypass,
  input  wire logic        decoder_bypass,
  input  wire logic        tx_fifo_bypass,
  input  wire logic [1:0]  fabric_width_sel,
  input  wire logic        comma_any_pattern,
  input  wire logic [1:0]  comma_polarity_sel,
  // Fabric transmit side.
  input  wire logic        tx_write,
  input  wire logic [31:0] tx_byte_in,
  input  wire logic [3:0]  tx_control_char_in,
  input  wire logic [3:0]  tx_disparity_force_mode,
  input  wire logic [3:0]  tx_disparity_force_value,
  output logic             tx_running_disparity_out,
  output logic             tx_bad_control_char_err,
  output logic             tx_fifo_overflow,
  output logic             tx_fifo_underflow,
  // Serialiser side.
  input  wire logic        tx_char_request,
  output logic [9:0]       tx_char_out,
  output logic             tx_char_valid,
  input  wire logic        rx_char_strobe,
  input  wire logic [9:0]  rx_char_in,
  // Fabric receive side.
  output logic             rx_word_valid,
  output logic [31:0]      rx_byte_out,
  output logic [3:0]       rx_control_char_flag,
  output logic [3:0]       rx_running_disparity_out,
  output logic [3:0]       rx_disparity_err,
  output logic [3:0]       rx_out_of_band_err,
  output logic [3:0]       rx_comma_detect
);
  import sctf_pkg::*;

  localparam logic [5:0] SCTF_SIX_NEG [0:`SCTF_SIX_ENTRIES-1] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] SCTF_FOUR_NEG [0:`SCTF_FOUR_ENTRIES-1] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  function automatic logic [1:0] sctf_last_lane(input logic [1:0] width_sel);
    case (width_sel)
      `SCTF_WIDTH_1: sctf_last_lane = `SCTF_LAST_1;
      `SCTF_WIDTH_2: sctf_last_lane = `SCTF_LAST_2;
      default:       sctf_last_lane = `SCTF_LAST_4;
    endcase
  endfunction : sctf_last_lane

  function automatic logic sctf_valid_k(input logic [7:0] data);
    logic [4:0] five;
    five = data[4:0];
    sctf_valid_k = (five == `SCTF_K28_FIVE) ||
                   ((data[7:5] == `SCTF_X7_THREE) &&
                    ((five == `SCTF_K23_FIVE) || (five == `SCTF_K27_FIVE) ||
                     (five == `SCTF_K29_FIVE) || (five == `SCTF_K30_FIVE)));
  endfunction : sctf_valid_k

  // Both sub-blocks are chosen from the negative-disparity form and flipped as needed.
  function automatic sctf_enc_type sctf_encode(input logic [7:0] data, input logic k, input logic rd);
    logic [5:0]   six;
    logic [3:0]   four;
    logic         rd_mid;
    logic         k28;
    logic         alt;
    logic         flip4;
    sctf_enc_type res;
    k28 = k && (data[4:0] == `SCTF_K28_FIVE);
    six = k28 ? `SCTF_K28_SIX_NEG : SCTF_SIX_NEG[data[4:0]];
    if (rd && (($countones(six) != `SCTF_BAL6) || (data[4:0] == `SCTF_D7_FIVE)))
      six = ~six;
    rd_mid = ($countones(six) == `SCTF_BAL6) ? rd : ~rd;
    alt = (data[7:5] == `SCTF_X7_THREE) &&
          (k || (!rd_mid && six[1] && six[0]) || (rd_mid && !six[1] && !six[0]));
    four = alt ? `SCTF_ALT7_NEG : SCTF_FOUR_NEG[data[7:5]];
    if (k28 && ($countones(four) == `SCTF_BAL4) && (data[7:5] != `SCTF_X3_THREE))
      flip4 = !rd_mid;
    else
      flip4 = rd_mid && (($countones(four) != `SCTF_BAL4) || (data[7:5] == `SCTF_X3_THREE));
    if (flip4)
      four = ~four;
    res.code = {six, four};
    res.rd = ($countones(four) == `SCTF_BAL4) ? rd_mid : ~rd_mid;
    return res;
  endfunction : sctf_encode

  // Decoding guesses the byte from the sub-blocks, then proves it by encoding it again.
  function automatic sctf_rx_char_type sctf_decode(input logic [9:0] code, input logic rd);
    logic [5:0]       six;
    logic [3:0]       four;
    logic [4:0]       five;
    logic [2:0]       three;
    logic             k28;
    logic             alt;
    logic             k;
    logic             found6;
    logic             found4;
    sctf_enc_type     same;
    sctf_enc_type     opp;
    sctf_rx_char_type res;
    six = code[9:4];
    four = code[3:0];
    five = '0;
    three = '0;
    found6 = 1'b0;
    found4 = 1'b0;
    alt = 1'b0;
    k28 = (six == `SCTF_K28_SIX_NEG) || (six == `SCTF_K28_SIX_POS);
    if (k28)
    begin
      five = `SCTF_K28_FIVE;
      found6 = 1'b1;
      if (six == `SCTF_K28_SIX_POS)
        four = ~four;
    end
    for (int f = 0; f < `SCTF_SIX_ENTRIES; f++)
    begin
      if (!k28 && ((six == SCTF_SIX_NEG[f]) ||
          ((($countones(SCTF_SIX_NEG[f]) != `SCTF_BAL6) || (f == `SCTF_D7_FIVE)) &&
           (six == ~SCTF_SIX_NEG[f]))))
      begin
        five = 5'(f);
        found6 = 1'b1;
      end
    end
    for (int x = 0; x < `SCTF_FOUR_ENTRIES; x++)
    begin
      if ((four == SCTF_FOUR_NEG[x]) ||
          ((($countones(SCTF_FOUR_NEG[x]) != `SCTF_BAL4) || (x == `SCTF_X3_THREE)) &&
           (four == ~SCTF_FOUR_NEG[x])))
      begin
        three = 3'(x);
        found4 = 1'b1;
      end
    end
    if ((four == `SCTF_ALT7_NEG) || (four == ~`SCTF_ALT7_NEG))
    begin
      three = `SCTF_X7_THREE;
      alt = 1'b1;
      found4 = 1'b1;
    end
    k = k28 || (alt && sctf_valid_k({three, five}));
    same = sctf_encode({three, five}, k, rd);
    opp = sctf_encode({three, five}, k, ~rd);
    res.data = {three, five};
    res.k = k;
    res.oob_err = !(found6 && found4 && ((same.code == code) || (opp.code == code)));
    res.disp_err = !res.oob_err && (same.code != code);
    res.comma = 1'b0;
    if ($countones(code) > `SCTF_BAL10)
      res.rd = 1'b1;
    else if ($countones(code) < `SCTF_BAL10)
      res.rd = 1'b0;
    else
      res.rd = rd;
    return res;
  endfunction : sctf_decode

  sctf_tx_word_type  in_word;
  sctf_tx_word_type  head_word;
  sctf_tx_word_type  fifo_rdata;
  sctf_tx_word_type  cur_word_ff;
  sctf_tx_word_type  byp_word_ff;
  logic              byp_valid_ff;
  logic [`SCTF_PTR_W:0] wr_ptr_ff;
  logic [`SCTF_PTR_W:0] rd_ptr_ff;
  logic [`SCTF_PTR_W:0] nxt_rd_ptr;
  logic              fifo_full;
  logic              fifo_empty;
  logic              fifo_we;
  logic              head_avail;
  logic              tx_start;
  logic              tx_emit;
  logic [1:0]        tx_last;
  sctf_tx_state_type tx_state_ff;
  logic [1:0]        tx_lane_ff;
  logic              tx_rd_ff;
  logic              tx_rd_use;
  sctf_tx_char_type  tx_char;
  sctf_enc_type      tx_enc;
  logic [9:0]        tx_char_ff;
  logic              tx_valid_ff;
  logic              tx_kerr_ff;
  logic              tx_ovf_ff;
  logic              tx_unf_ff;
  sctf_rx_char_type  rx_dec;
  sctf_rx_char_type  rx_char;
  sctf_rx_word_type  rx_acc_ff;
  sctf_rx_word_type  nxt_rx_word;
  sctf_rx_word_type  rx_word_ff;
  logic              rx_valid_ff;
  logic [1:0]        rx_lane_ff;
  logic              rx_rd_ff;
  logic              comma_hit;

  // Per-lane control inputs become encoder controls with 8-bit data, code bits 9:8 in bypass.
  always_comb
  begin
    for (int l = 0; l < `SCTF_LANES; l++)
    begin
      in_word[l].mode = tx_disparity_force_mode[l];
      in_word[l].value = tx_disparity_force_value[l];
      in_word[l].k = tx_control_char_in[l];
      in_word[l].data = tx_byte_in[8*l +: 8];
    end
  end

  // Reads and writes share one clock, so the FIFO only absorbs phase, never rate.
  assign fifo_full = ((wr_ptr_ff - rd_ptr_ff) == `SCTF_FIFO_DEPTH);
  assign fifo_empty = (wr_ptr_ff == rd_ptr_ff);
  assign fifo_we = tx_write && !tx_fifo_bypass && !fifo_full;
  assign head_avail = tx_fifo_bypass ? byp_valid_ff : !fifo_empty;
  assign head_word = tx_fifo_bypass ? byp_word_ff : fifo_rdata;
  assign tx_last = sctf_last_lane(fabric_width_sel);
  assign tx_start = tx_char_request && (tx_state_ff == SCTF_TX_IDLE) && head_avail;
  assign tx_emit = tx_char_request && ((tx_state_ff == SCTF_TX_SEND) || head_avail);
  assign nxt_rd_ptr = rd_ptr_ff + {{`SCTF_PTR_W{1'b0}}, (tx_start && !tx_fifo_bypass)};

  sctf_fifo_mem u_fifo_mem
  (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .we       (fifo_we),
    .waddr    (wr_ptr_ff[`SCTF_PTR_W-1:0]),
    .wdata    (in_word),
    .raddr    (nxt_rd_ptr[`SCTF_PTR_W-1:0]),
    .rdata_ff (fifo_rdata)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else if (ce)
    begin
      if (fifo_we)
        wr_ptr_ff <= wr_ptr_ff + {{`SCTF_PTR_W{1'b0}}, 1'b1};
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // The single bypass register is overwritten when not drained; that counts as overflow.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      byp_word_ff <= '0;
      byp_valid_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (tx_write && tx_fifo_bypass)
      begin
        byp_word_ff <= in_word;
        byp_valid_ff <= 1'b1;
      end
      else if (tx_start && tx_fifo_bypass)
        byp_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_ovf_ff <= 1'b0;
      tx_unf_ff <= 1'b0;
    end
    else if (ce)
    begin
      tx_ovf_ff <= tx_write && (tx_fifo_bypass ? (byp_valid_ff && !tx_start) : fifo_full);
      tx_unf_ff <= tx_char_request && !tx_emit;
    end
  end

  // Lane 0 of a fresh word goes out on the same request that takes it, so no bubble.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_state_ff <= SCTF_TX_IDLE;
      tx_lane_ff <= '0;
      cur_word_ff <= '0;
    end
    else if (ce)
    begin
      unique case (tx_state_ff)
        SCTF_TX_IDLE:
        begin
          if (tx_start)
          begin
            cur_word_ff <= head_word;
            tx_lane_ff <= 2'h1;
            if (tx_last != `SCTF_LAST_1)
              tx_state_ff <= SCTF_TX_SEND;
          end
        end
        SCTF_TX_SEND:
        begin
          if (tx_char_request)
          begin
            if (tx_lane_ff == tx_last)
            begin
              tx_state_ff <= SCTF_TX_IDLE;
              tx_lane_ff <= '0;
            end
            else
              tx_lane_ff <= tx_lane_ff + 2'h1;
          end
        end
      endcase
    end
  end

  assign tx_char = (tx_state_ff == SCTF_TX_SEND) ? cur_word_ff[tx_lane_ff] : head_word[0];
  assign tx_rd_use = tx_char.mode ? tx_char.value :
                     (tx_char.value ? ~tx_rd_ff : tx_rd_ff);
  assign tx_enc = sctf_encode(tx_char.data, tx_char.k, tx_rd_use);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_rd_ff <= `SCTF_RD_NEG;
      tx_char_ff <= '0;
      tx_valid_ff <= 1'b0;
      tx_kerr_ff <= 1'b0;
    end
    else if (ce)
    begin
      tx_valid_ff <= tx_emit;
      tx_kerr_ff <= tx_emit && !encoder_bypass && tx_char.k && !sctf_valid_k(tx_char.data);
      if (tx_emit)
      begin
        if (encoder_bypass)
          tx_char_ff <= {tx_char.mode, tx_char.value, tx_char.data};
        else
        begin
          tx_char_ff <= tx_enc.code;
          tx_rd_ff <= tx_enc.rd;
        end
      end
    end
  end

  assign rx_dec = sctf_decode(rx_char_in, rx_rd_ff);
  assign comma_hit = (comma_polarity_sel[0] && (rx_char_in[9:3] == `SCTF_COMMA_PLUS)) ||
                     (comma_polarity_sel[1] && (rx_char_in[9:3] == `SCTF_COMMA_MINUS));

  always_comb
  begin
    rx_char = rx_dec;
    if (decoder_bypass)
    begin
      rx_char = '0;
      rx_char.k = rx_char_in[9];
      rx_char.rd = rx_char_in[8];
      rx_char.data = rx_char_in[7:0];
    end
    else if (rx_dec.oob_err)
    begin
      rx_char.k = rx_char_in[9];
      rx_char.rd = rx_char_in[8];
      rx_char.data = rx_char_in[7:0];
    end
    if (comma_any_pattern)
      rx_char.comma = comma_hit;
    else
      rx_char.comma = comma_hit && !decoder_bypass && !rx_dec.oob_err && rx_dec.k &&
                      ((rx_dec.data == `SCTF_K28_1) || (rx_dec.data == `SCTF_K28_5) ||
                       (rx_dec.data == `SCTF_K28_7));
    nxt_rx_word = rx_acc_ff;
    nxt_rx_word[rx_lane_ff] = rx_char;
  end

  // Lanes fill from the least-significant end, in the order characters arrive.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_rd_ff <= `SCTF_RD_NEG;
      rx_lane_ff <= '0;
      rx_acc_ff <= '0;
      rx_word_ff <= '0;
      rx_valid_ff <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid_ff <= 1'b0;
      if (rx_char_strobe)
      begin
        if (!decoder_bypass)
          rx_rd_ff <= rx_dec.rd;
        if (rx_lane_ff == sctf_last_lane(fabric_width_sel))
        begin
          rx_word_ff <= nxt_rx_word;
          rx_valid_ff <= 1'b1;
          rx_acc_ff <= '0;
          rx_lane_ff <= '0;
        end
        else
        begin
          rx_acc_ff <= nxt_rx_word;
          rx_lane_ff <= rx_lane_ff + 2'h1;
        end
      end
    end
  end

  assign tx_running_disparity_out = tx_rd_ff;
  assign tx_bad_control_char_err = tx_kerr_ff;
  assign tx_fifo_overflow = tx_ovf_ff;
  assign tx_fifo_underflow = tx_unf_ff;
  assign tx_char_out = tx_char_ff;
  assign tx_char_valid = tx_valid_ff;
  assign rx_word_valid = rx_valid_ff;

  always_comb
  begin
    for (int l = 0; l < `SCTF_LANES; l++)
    begin
      rx_byte_out[8*l +: 8] = rx_word_ff[l].data;
      rx_control_char_flag[l] = rx_word_ff[l].k;
      rx_running_disparity_out[l] = rx_word_ff[l].rd;
      rx_disparity_err[l] = rx_word_ff[l].disp_err;
      rx_out_of_band_err[l] = rx_word_ff[l].oob_err;
      rx_comma_detect[l] = rx_word_ff[l].comma;
    end
  end
endmodule : sctf_codec
`default_nettype wire

// ==== verilog/sctf_defines.svh ====
`ifndef SCTF_DEFINES_SVH
`define SCTF_DEFINES_SVH
`define SCTF_LANES 4
`define SCTF_PTR_W 2
`define SCTF_FIFO_DEPTH 3'h4
`define SCTF_RD_NEG 1'b0
`define SCTF_WIDTH_1 2'h0
`define SCTF_WIDTH_2 2'h1
`define SCTF_LAST_1 2'h0
`define SCTF_LAST_2 2'h1
`define SCTF_LAST_4 2'h3
`define SCTF_SIX_ENTRIES 32
`define SCTF_FOUR_ENTRIES 8
`define SCTF_BAL6 3
`define SCTF_BAL4 2
`define SCTF_BAL10 5
`define SCTF_K28_FIVE 5'h1c
`define SCTF_K23_FIVE 5'h17
`define SCTF_K27_FIVE 5'h1b
`define SCTF_K29_FIVE 5'h1d
`define SCTF_K30_FIVE 5'h1e
`define SCTF_D7_FIVE 5'h07
`define SCTF_X3_THREE 3'h3
`define SCTF_X7_THREE 3'h7
`define SCTF_K28_SIX_NEG 6'h0f
`define SCTF_K28_SIX_POS 6'h30
`define SCTF_ALT7_NEG 4'h7
`define SCTF_COMMA_PLUS 7'h1f
`define SCTF_COMMA_MINUS 7'h60
`define SCTF_K28_1 8'h3c
`define SCTF_K28_5 8'hbc
`define SCTF_K28_7 8'hfc
`endif

// ==== verilog/sctf_pkg.sv ====
`default_nettype none
`include "sctf_defines.svh"
package sctf_pkg;
  typedef struct packed {
    logic       mode;
    logic       value;
    logic       k;
    logic [7:0] data;
  } sctf_tx_char_type;
  typedef sctf_tx_char_type [`SCTF_LANES-1:0] sctf_tx_word_type;
  typedef struct packed {
    logic [9:0] code;
    logic       rd;
  } sctf_enc_type;
  typedef struct packed {
    logic       k;
    logic       rd;
    logic       disp_err;
    logic       oob_err;
    logic       comma;
    logic [7:0] data;
  } sctf_rx_char_type;
  typedef sctf_rx_char_type [`SCTF_LANES-1:0] sctf_rx_word_type;
  typedef enum logic [1:0] {
    SCTF_TX_IDLE = 2'b01,
    SCTF_TX_SEND = 2'b10
  } sctf_tx_state_type;
endpackage : sctf_pkg
`default_nettype wire

// ==== verilog/sctf_fifo_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sctf_defines.svh"
module sctf_fifo_mem
(
  // Clocking.
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  // Write port.
  input  wire logic                    we,
  input  wire logic [`SCTF_PTR_W-1:0]  waddr,
  input  wire sctf_pkg::sctf_tx_word_type wdata,
  // Read port.
  input  wire logic [`SCTF_PTR_W-1:0]  raddr,
  output sctf_pkg::sctf_tx_word_type   rdata_ff
);
  import sctf_pkg::*;

  sctf_tx_word_type mem [0:(1<<`SCTF_PTR_W)-1];

  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // A write to the entry being read is forwarded so a just-written head is not stale.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_ff <= '0;
    end
    else if (ce)
    begin
      rdata_ff <= (we && (waddr == raddr)) ? wdata : mem[raddr];
    end
  end
endmodule : sctf_fifo_mem
`default_nettype wire

// ==== bench/sctf_codec_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sctf_codec_checker
(
  // Clock and configuration.
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        encoder_bypass,
  input wire logic        decoder_bypass,
  input wire logic [1:0]  fabric_width_sel,
  input wire logic [1:0]  comma_polarity_sel,
  // Transmit side.
  input wire logic        tx_write,
  input wire logic        tx_running_disparity_out,
  input wire logic        tx_bad_control_char_err,
  input wire logic        tx_fifo_overflow,
  input wire logic        tx_fifo_underflow,
  input wire logic        tx_char_request,
  input wire logic        tx_char_valid,
  // Receive side.
  input wire logic        rx_char_strobe,
  input wire logic [9:0]  rx_char_in,
  input wire logic        rx_word_valid,
  input wire logic [31:0] rx_byte_out,
  input wire logic [3:0]  rx_control_char_flag,
  input wire logic [3:0]  rx_running_disparity_out,
  input wire logic [3:0]  rx_out_of_band_err,
  input wire logic [3:0]  rx_comma_detect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_serve;
    ##1 (tx_char_valid ^ tx_fifo_underflow);
  endsequence
  sequence s_bypass_char;
    rx_char_strobe && fabric_width_sel == 2'h0 && decoder_bypass;
  endsequence
  sequence s_coded_char;
    rx_char_strobe && fabric_width_sel == 2'h0 && !decoder_bypass;
  endsequence
  property p_reset_rd; $fell(reset) |-> !tx_running_disparity_out && !tx_char_valid; endproperty
  a_reset_rd: assert property (p_reset_rd) else $error("state not clear after reset");
  property p_serve; ce && tx_char_request |-> s_serve; endproperty
  a_serve: assert property (p_serve) else $error("request without single answer");
  property p_valid_cause; tx_char_valid |-> $past(tx_char_request); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("character without request");
  property p_over_cause; tx_fifo_overflow |-> $past(tx_write); endproperty
  a_over_cause: assert property (p_over_cause) else $error("overflow without write");
  property p_bad_k; tx_bad_control_char_err |-> tx_char_valid && !encoder_bypass; endproperty
  a_bad_k: assert property (p_bad_k) else $error("control error out of place");
  property p_rd_hold; !tx_char_valid |-> $stable(tx_running_disparity_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("disparity moved without character");
  property p_rx_cause; rx_word_valid |-> $past(rx_char_strobe); endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("word without strobe");
  property p_rx_raw;
    s_bypass_char |=> rx_word_valid && rx_byte_out[7:0] == $past(rx_char_in[7:0])
      && rx_control_char_flag[0] == $past(rx_char_in[9]) && rx_running_disparity_out[0] == $past(rx_char_in[8]);
  endproperty
  a_rx_raw: assert property (p_rx_raw) else $error("bypass bit mapping wrong");
  property p_oob_raw;
    s_coded_char |=> !rx_out_of_band_err[0]
      || (rx_byte_out[7:0] == $past(rx_char_in[7:0]) && rx_control_char_flag[0] == $past(rx_char_in[9]));
  endproperty
  a_oob_raw: assert property (p_oob_raw) else $error("illegal code not passed raw");
  property p_comma; s_coded_char ##0 (rx_char_in == 10'h0fa && comma_polarity_sel[0]) |=> rx_comma_detect[0]; endproperty
  a_comma: assert property (p_comma) else $error("comma missed");
endmodule : sctf_codec_checker
bind sctf_codec sctf_codec_checker u_sctf_codec_checker
(
  .*
);
`default_nettype wire

// ==== bench/sctf_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sctf_line_model
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Scenario control.
  input  wire logic       req_en,
  input  wire logic       inj_go,
  input  wire logic [9:0] inj_code,
  // Codec line side.
  input  wire logic [9:0] tx_char_out,
  input  wire logic       tx_char_valid,
  output logic            tx_char_request,
  output logic            rx_char_strobe,
  output logic [9:0]      rx_char_in
);
  logic       req_ff    = 1'h0;
  logic       strobe_ff = 1'h0;
  logic [9:0] code_ff   = 10'h0;
  // Sharing the fabric clock keeps the line frequency-locked.
  always @(posedge clk)
  begin
    req_ff    <= req_en && !reset;
    strobe_ff <= !reset && (inj_go || tx_char_valid);
    code_ff   <= inj_go ? inj_code : tx_char_valid ? tx_char_out : ~code_ff;
  end
  assign tx_char_request = req_ff;
  assign rx_char_strobe  = strobe_ff;
  assign rx_char_in      = code_ff;
endmodule : sctf_line_model
`default_nettype wire

// ==== bench/sctf_codec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module sctf_codec_bench;
  logic        clk, reset, ce, encoder_bypass, decoder_bypass, tx_fifo_bypass, comma_any_pattern;
  logic        tx_write, tx_running_disparity_out, tx_bad_control_char_err, tx_fifo_overflow;
  logic        tx_fifo_underflow, tx_char_request, tx_char_valid, rx_char_strobe, rx_word_valid;
  logic        req_en, inj_go;
  logic [1:0]  fabric_width_sel, comma_polarity_sel;
  logic [3:0]  tx_control_char_in, tx_disparity_force_mode, tx_disparity_force_value;
  logic [3:0]  rx_control_char_flag, rx_running_disparity_out, rx_disparity_err;
  logic [3:0]  rx_out_of_band_err, rx_comma_detect;
  logic [9:0]  tx_char_out, rx_char_in, inj_code;
  logic [31:0] tx_byte_in, rx_byte_out;
  int          failures, n_compared, n_ovf, n_unf, n_val;
  sctf_codec u_sctf_codec
  (
    .*
  );
  sctf_line_model u_sctf_line_model
  (
    .*
  );
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (tx_fifo_overflow === 1'h1) n_ovf++;
    if (tx_fifo_underflow === 1'h1) n_unf++;
    if (tx_char_valid === 1'h1) n_val++;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task conclude;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task restart;
    reset = 1'h1;
    repeat (4) @(negedge clk);
    reset = 1'h0;
  endtask : restart
  task automatic wait_hi(ref logic f);
    int i;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (f !== 1'h1 && i < 20);
  endtask : wait_hi
  task put(input logic [3:0] k, input logic [3:0] m, input logic [3:0] v, input logic [31:0] d);
    tx_write = 1'h1;
    tx_control_char_in = k;
    tx_disparity_force_mode = m;
    tx_disparity_force_value = v;
    tx_byte_in = d;
    @(negedge clk);
  endtask : put
  task send(input logic [3:0] k, input logic [3:0] m, input logic [3:0] v, input logic [31:0] d);
    put(k, m, v, d);
    tx_write = 1'h0;
  endtask : send
  task get_tx(input logic [9:0] e);
    wait_hi(tx_char_valid);
    check({tx_char_valid, tx_bad_control_char_err, tx_char_out}, {2'h2, e});
  endtask : get_tx
  task rx0(input logic [12:0] e);
    wait_hi(rx_word_valid);
    check({rx_word_valid, rx_control_char_flag[0], rx_running_disparity_out[0], rx_disparity_err[0],
           rx_out_of_band_err[0], rx_comma_detect[0], rx_byte_out[7:0]}, {1'h1, e});
  endtask : rx0
  task inject(input logic [9:0] c);
    inj_go = 1'h1;
    inj_code = c;
    @(negedge clk);
    inj_go = 1'h0;
  endtask : inject
  task comma(input logic [9:0] c, input logic e);
    inject(c);
    wait_hi(rx_word_valid);
    check({rx_word_valid, rx_comma_detect[0]}, {1'h1, e});
  endtask : comma
  task done(input string s);
    $display("test %0s finished", s);
  endtask : done
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude;
  end
  initial
  begin
    clk = 1'h0;
    reset = 1'h1;
    {ce, encoder_bypass, decoder_bypass, tx_fifo_bypass, comma_any_pattern, tx_write, req_en, inj_go} = 8'h80;
    {fabric_width_sel, comma_polarity_sel} = 4'h3;
    {tx_control_char_in, tx_disparity_force_mode, tx_disparity_force_value} = 12'h0;
    tx_byte_in = 32'h0;
    inj_code = 10'h0;
    restart;
    check(tx_running_disparity_out, 1'h0);
    req_en = 1'h1;
    send(4'h1, 4'h0, 4'h0, 32'hbc);
    get_tx(10'h0fa);
    check(tx_running_disparity_out, 1'h1);
    rx0({5'h19, 8'hbc});
    send(4'h1, 4'h0, 4'h1, 32'hbc);
    get_tx(10'h0fa);
    rx0({5'h1d, 8'hbc});
    send(4'h1, 4'h1, 4'h1, 32'hbc);
    get_tx(10'h305);
    check(tx_running_disparity_out, 1'h0);
    rx0({5'h11, 8'hbc});
    send(4'h0, 4'h0, 4'h0, 32'h0);
    get_tx(10'h274);
    rx0({5'h00, 8'h00});
    send(4'h1, 4'h0, 4'h0, 32'h01);
    wait_hi(tx_char_valid);
    check(tx_bad_control_char_err, 1'h1);
    done("encoder");
    req_en = 1'h0;
    encoder_bypass = 1'h1;
    restart;
    for (int i = 1; i <= 5; i++) put(4'h0, {3'h0, i[1]}, {3'h0, i[0]}, 32'(i));
    tx_write = 1'h0;
    n_ovf = 0;
    @(negedge clk);
    check(n_ovf, 32'h1);
    ce = 1'h0;
    n_val = 0;
    n_unf = 0;
    req_en = 1'h1;
    repeat (3) @(negedge clk);
    check(n_val, 32'h0);
    ce = 1'h1;
    for (int i = 1; i <= 4; i++) get_tx({i[1], i[0], 8'(i)});
    repeat (4) @(negedge clk);
    check(n_val, 32'h4);
    check(n_unf > 0, 1'h1);
    req_en = 1'h0;
    tx_fifo_bypass = 1'h1;
    @(negedge clk);
    n_ovf = 0;
    put(4'h0, 4'h0, 4'h0, 32'h0a);
    put(4'h0, 4'h0, 4'h0, 32'h0b);
    tx_write = 1'h0;
    @(negedge clk);
    check(n_ovf, 32'h1);
    req_en = 1'h1;
    get_tx(10'h00b);
    done("fifo");
    tx_fifo_bypass = 1'h0;
    decoder_bypass = 1'h1;
    fabric_width_sel = 2'h2;
    restart;
    send(4'h0, 4'h5, 4'h3, 32'h44332211);
    get_tx(10'h311);
    get_tx(10'h122);
    get_tx(10'h233);
    get_tx(10'h044);
    wait_hi(rx_word_valid);
    check({rx_control_char_flag, rx_running_disparity_out}, 8'h53);
    check(rx_byte_out, 32'h44332211);
    for (int w = 0; w < 2; w++)
    begin
      fabric_width_sel = w[1:0];
      send(4'h0, 4'h1, 4'h0, 32'hffff665a);
      get_tx(10'h25a);
      if (w == 1) get_tx(10'h066);
      wait_hi(rx_word_valid);
      check(rx_byte_out, (w == 1) ? 32'h665a : 32'h5a);
    end
    done("widths");
    {encoder_bypass, decoder_bypass, req_en} = 3'h0;
    {fabric_width_sel, comma_polarity_sel} = 4'h1;
    restart;
    inject(10'h305);
    rx0({5'h14, 8'hbc});
    inject(10'h3e0);
    wait_hi(rx_word_valid);
    check({rx_control_char_flag[0], rx_running_disparity_out[0], rx_out_of_band_err[0], rx_byte_out[7:0]},
          {3'h7, 8'he0});
    for (int a = 0; a < 2; a++)
      for (int p = 1; p < 4; p++)
      begin
        comma_any_pattern = a[0];
        comma_polarity_sel = p[1:0];
        comma(10'h0fa, p[0]);
        comma(10'h305, p[1]);
        comma(10'h300, a[0] & p[1]);
      end
    done("receive");
    conclude;
  end
endmodule : sctf_codec_bench
`default_nettype wire
